//--- verilog/ptcu_pkg.sv
package ptcu_pkg;
  // Timebase selection codes.
  localparam logic [1:0] PTCU_TB_1MS = 2'h0;
  localparam logic [1:0] PTCU_TB_10MS = 2'h1;
  localparam logic [1:0] PTCU_TB_100MS = 2'h2;
  // Clock and timebase figures.
  localparam int PTCU_CLK_MHZ = 100;
  localparam int PTCU_TICK_US = 1000;
  localparam int PTCU_TICK_CYC = PTCU_TICK_US * PTCU_CLK_MHZ;
  localparam int PTCU_DIV10 = 10;
  localparam int PTCU_DIV100 = 100;
  // Counter limits and reset values.
  localparam logic [14:0] PTCU_C16_MAX = 15'h7fff;
  localparam logic [31:0] PTCU_HS_MAX = 32'h7fffffff;
  localparam logic [15:0] PTCU_T_RST = 16'h0000;
  localparam logic [31:0] PTCU_C_RST = 32'h00000000;
  // Pulse input budget.
  localparam int PTCU_HS_MAX_KHZ = 20;
  // Number of single-phase high-speed counters sharing the common reset.
  localparam int PTCU_HS_SHARED = 5;
endpackage

//--- verilog/ptcu_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Timers count up in 1/10/100 ms ticks.
// - End-of-scan variant advances once per scan.
// - Instruction variant advances on instruction evaluation.
// - Enabled timer flags when value reaches preset.
// - General timer clears on enable loss.
// - Retentive timer holds value and resumes.
// - Routine timers count at end of scan.
// - Routine timer idle when routine not executing.
// - Counters act on rising count edge; the 32-bit counter steps at the following end of scan.
// - 16-bit counter counts up to 32767, flags.
// - 16-bit counter stops at preset until reset or load.
// - 32-bit up/down counter wraps past maximum.
// - 32-bit flag tracks value at or above preset.
// - Direction bit set means count down.
// - High-speed counter wraps to zero after maximum.
// - High-speed compare acts immediately on match.
// - 32-bit counter per scan, 16-bit and high-speed per pulse.
// - Reset clears value and output flag.
// - Overloaded 16-bit counter snaps to preset.
// - Pulse inputs accept up to 20 kHz.
// - Each high-speed counter has fixed inputs.
// - Shared input counts or resets five counters.
module ptcu_top
  import ptcu_pkg::*;
#(
  parameter int TICK_CYC = PTCU_TICK_CYC,
  parameter int HS_N = 6
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Scan engine.
  input wire logic i_end_of_scan,
  input wire logic i_eval_mode,
  // Timer commands.
  input wire logic [1:0] i_tmr_base,
  input wire logic i_tmr_enable,
  input wire logic i_tmr_retentive,
  input wire logic i_tmr_routine,
  input wire logic i_tmr_routine_active,
  input wire logic i_tmr_eval,
  input wire logic [15:0] i_tmr_preset,
  // 16-bit counter.
  input wire logic i_c16_count,
  input wire logic i_c16_reset,
  input wire logic i_c16_load,
  input wire logic [14:0] i_c16_load_value,
  input wire logic [14:0] i_c16_preset,
  // 32-bit up/down counter.
  input wire logic i_c32_count,
  input wire logic i_c32_reset,
  input wire logic i_count_down_select_bit,
  input wire logic [31:0] i_c32_preset,
  // High-speed counters on fixed pulse inputs.
  input wire logic [HS_N-1:0] i_hs_pulse,
  input wire logic [HS_N-1:0] i_hs_reset,
  input wire logic [HS_N-1:0] i_hs_down,
  input wire logic i_shared_input_role_select,
  input wire logic [31:0] i_hs_preset,
  // Outputs.
  output logic [15:0] o_tmr_value,
  output logic o_tmr_flag,
  output logic [14:0] o_c16_value,
  output logic o_c16_flag,
  output logic [31:0] o_c32_value,
  output logic o_c32_flag,
  output logic [HS_N*32-1:0] o_hs_value,
  output logic [HS_N-1:0] o_hs_flag
);
  initial begin
    if (HS_N != PTCU_HS_SHARED + 1) $error("HS_N must be shared count plus one");
    if (TICK_CYC < 1) $error("TICK_CYC must be at least one");
  end

  typedef struct packed {
    logic [31:0] pre;
    logic [6:0] dec;
    logic tick_pend;
    logic [15:0] tv;
    logic tf;
    logic c16_prev;
    logic [14:0] c16v;
    logic c16f;
    logic c32_prev;
    logic c32_pend;
    logic [31:0] c32v;
    logic c32f;
    logic [HS_N-1:0] hs_prev;
    logic [HS_N*32-1:0] hsv;
    logic [HS_N-1:0] hsf;
  } ptcu_state_s;

  ptcu_state_s st_r;
  ptcu_state_s st_nxt;

  // Millisecond ticks per timer step, less one, per selected timebase.
  function automatic logic [6:0] ptcu_div(input logic [1:0] base);
    case (base)
      PTCU_TB_10MS: ptcu_div = 7'(PTCU_DIV10 - 1);
      PTCU_TB_100MS: ptcu_div = 7'(PTCU_DIV100 - 1);
      default: ptcu_div = 7'h0;
    endcase
  endfunction

  logic ms_tick;
  logic base_tick;
  logic tmr_run;
  logic tmr_step;
  logic [31:0] hs_cur;
  logic hs_rst;
  logic hs_edge;

  always_comb begin
    st_nxt = st_r;
    ms_tick = (st_r.pre == 32'(TICK_CYC - 1));
    st_nxt.pre = ms_tick ? 32'h0 : st_r.pre + 32'h1;
    // Timebase: 1 ms raw, 10 and 100 ms from one shared millisecond prescaler.
    base_tick = 1'b0;
    if (ms_tick) begin
      if (st_r.dec >= ptcu_div(i_tmr_base)) begin
        st_nxt.dec = 7'h0;
        base_tick = 1'b1;
      end else begin
        st_nxt.dec = st_r.dec + 7'h1;
      end
    end
    if (base_tick) begin
      st_nxt.tick_pend = 1'b1;
    end
    // Routine timers only run while their routine executes.
    tmr_run = i_tmr_enable && (!i_tmr_routine || i_tmr_routine_active);
    // End-of-scan or instruction point, a routine timer always at end of scan.
    tmr_step = (i_tmr_routine || !i_eval_mode) ? i_end_of_scan : i_tmr_eval;
    if (!i_tmr_enable) begin
      st_nxt.tf = 1'b0;
      if (!i_tmr_retentive) begin
        st_nxt.tv = PTCU_T_RST;
      end
    end else if (tmr_run && tmr_step) begin
      if ((st_r.tick_pend || base_tick) && st_r.tv < i_tmr_preset) begin
        st_nxt.tv = st_r.tv + 16'h1;
        st_nxt.tick_pend = 1'b0;
      end
      st_nxt.tf = (st_r.tv >= i_tmr_preset) ||
        ((st_r.tick_pend || base_tick) && (st_r.tv + 16'h1 >= i_tmr_preset));
    end
    // The 16-bit counter steps on the edge; the 32-bit one waits for the scan point.
    st_nxt.c16_prev = i_c16_count;
    if (i_c16_reset) begin
      st_nxt.c16v = 15'h0;
      st_nxt.c16f = 1'b0;
    end else if (i_c16_load) begin
      st_nxt.c16v = i_c16_load_value;
    end else if (i_c16_count && !st_r.c16_prev) begin
      if (st_r.c16v >= i_c16_preset) begin
        st_nxt.c16v = i_c16_preset;
        st_nxt.c16f = 1'b1;
      end else if (st_r.c16v < PTCU_C16_MAX) begin
        st_nxt.c16v = st_r.c16v + 15'h1;
        st_nxt.c16f = (st_r.c16v + 15'h1 >= i_c16_preset);
      end
    end
    st_nxt.c32_prev = i_c32_count;
    if (i_c32_count && !st_r.c32_prev) begin
      st_nxt.c32_pend = 1'b1;
    end
    if (i_c32_reset) begin
      st_nxt.c32v = PTCU_C_RST;
      st_nxt.c32_pend = 1'b0;
      st_nxt.c32f = 1'b0;
    end else if (i_end_of_scan && (st_r.c32_pend || (i_c32_count && !st_r.c32_prev))) begin
      st_nxt.c32_pend = 1'b0;
      // Two's complement addition wraps from the top to the bottom of the range.
      st_nxt.c32v = i_count_down_select_bit ? st_r.c32v - 32'h1 : st_r.c32v + 32'h1;
    end
    st_nxt.c32f = !i_c32_reset && ($signed(st_nxt.c32v) >= $signed(i_c32_preset));
    // Shared input: counts when role select clear, resets five counters when set.
    st_nxt.hs_prev = i_hs_pulse;
    for (int k = 0; k < HS_N; k++) begin
      hs_cur = st_r.hsv[k*32 +: 32];
      hs_rst = i_hs_reset[k] ||
        (k < PTCU_HS_SHARED && i_shared_input_role_select && i_hs_pulse[HS_N-1]);
      hs_edge = i_hs_pulse[k] && !st_r.hs_prev[k] &&
        !(k == HS_N-1 && i_shared_input_role_select);
      if (hs_rst) begin
        hs_cur = PTCU_C_RST;
      end else if (hs_edge) begin
        if (i_hs_down[k]) begin
          hs_cur = (hs_cur == 32'h0) ? PTCU_HS_MAX : hs_cur - 32'h1;
        end else begin
          hs_cur = (hs_cur == PTCU_HS_MAX) ? 32'h0 : hs_cur + 32'h1;
        end
      end
      st_nxt.hsv[k*32 +: 32] = hs_cur;
      st_nxt.hsf[k] = !hs_rst && (hs_cur >= i_hs_preset);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register, so no glitch reaches the pins.
  assign o_tmr_value = st_r.tv;
  assign o_tmr_flag = st_r.tf;
  assign o_c16_value = st_r.c16v;
  assign o_c16_flag = st_r.c16f;
  assign o_c32_value = st_r.c32v;
  assign o_c32_flag = st_r.c32f;
  assign o_hs_value = st_r.hsv;
  assign o_hs_flag = st_r.hsf;

  chk_tmr_clear_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_tmr_enable && !i_tmr_retentive |=> o_tmr_value == 16'h0 && !o_tmr_flag)
    else $error("general timer not cleared");
  chk_tmr_hold_ret: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_tmr_enable && i_tmr_retentive |=> $stable(o_tmr_value))
    else $error("retentive timer lost value");
  chk_tmr_routine_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_tmr_routine && !i_tmr_routine_active && i_tmr_enable |=> $stable(o_tmr_value))
    else $error("routine timer advanced while idle");
  chk_c16_stop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_c16_flag && !i_c16_reset && !i_c16_load && $stable(i_c16_preset)
    |=> o_c16_value == $past(o_c16_value))
    else $error("16-bit counter moved past preset");
  chk_c16_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_c16_reset |=> o_c16_value == 15'h0 && !o_c16_flag)
    else $error("16-bit counter reset failed");
  chk_c32_flag_cmp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !$past(i_rst) && !$past(i_c32_reset)
    |-> o_c32_flag == ($signed(o_c32_value) >= $signed($past(i_c32_preset))))
    else $error("32-bit flag disagrees with compare");
  chk_c32_dir_down: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_end_of_scan && i_count_down_select_bit && !i_c32_reset
    && (st_r.c32_pend || (i_c32_count && !st_r.c32_prev))
    |=> o_c32_value == $past(o_c32_value) - 32'h1)
    else $error("32-bit counter did not count down");
  chk_hs_wrap_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_hs_value[31:0] == PTCU_HS_MAX && i_hs_pulse[0] && !$past(i_hs_pulse[0]) && !i_hs_down[0]
    && !i_hs_reset[0] && !(i_shared_input_role_select && i_hs_pulse[HS_N-1])
    |=> o_hs_value[31:0] == 32'h0)
    else $error("high-speed counter did not wrap");
  chk_hs_shared_rst: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_shared_input_role_select && i_hs_pulse[HS_N-1] |=> o_hs_value[31:0] == 32'h0)
    else $error("shared reset missed");

  chk_tmr_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_tmr_flag && i_tmr_enable && $stable(i_tmr_preset) |-> o_tmr_value >= i_tmr_preset)
    else $error("timer flag without reaching preset");
  chk_tmr_flag_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_tmr_enable |=> !o_tmr_flag)
    else $error("timer flag kept while disabled");
  chk_tmr_eos_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_tmr_enable && !i_eval_mode && !i_tmr_routine && !i_end_of_scan |=> $stable(o_tmr_value))
    else $error("timer stepped outside end of scan");
  chk_tmr_eval_point: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_tmr_enable && i_eval_mode && !i_tmr_routine && !i_tmr_eval |=> $stable(o_tmr_value))
    else $error("timer stepped outside evaluation");
  chk_tmr_routine_eos: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_tmr_enable && i_tmr_routine && !i_end_of_scan |=> $stable(o_tmr_value))
    else $error("routine timer stepped outside end of scan");

  chk_c16_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_c16_reset && !i_c16_load && i_c16_count && !$past(i_c16_count)
    && o_c16_value < i_c16_preset |=> o_c16_value == $past(o_c16_value) + 15'h1)
    else $error("16-bit counter missed an edge");
  chk_c16_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_c16_reset && !i_c16_load && !(i_c16_count && !$past(i_c16_count)) |=> $stable(o_c16_value))
    else $error("16-bit counter moved without an edge");
  chk_c16_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_c16_load && !i_c16_reset |=> o_c16_value == $past(i_c16_load_value))
    else $error("16-bit counter load lost");

  chk_c32_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_c32_reset |=> o_c32_value == 32'h0 && !o_c32_flag)
    else $error("32-bit counter reset failed");
  chk_c32_up: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_end_of_scan && !i_count_down_select_bit && !i_c32_reset
    && (st_r.c32_pend || (i_c32_count && !st_r.c32_prev)) |=> o_c32_value == $past(o_c32_value) + 32'h1)
    else $error("32-bit counter did not count up");

  chk_hs_flag_cmp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !$past(i_rst) && !$past(i_hs_reset[0]) && !$past(i_shared_input_role_select)
    |-> o_hs_flag[0] == (o_hs_value[31:0] >= $past(i_hs_preset)))
    else $error("high-speed flag disagrees with compare");
  chk_hs_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_hs_pulse[0] && !$past(i_hs_pulse[0]) && !i_hs_down[0] && !i_hs_reset[0]
    && !i_shared_input_role_select && o_hs_value[31:0] != PTCU_HS_MAX
    |=> o_hs_value[31:0] == $past(o_hs_value[31:0]) + 32'h1)
    else $error("high-speed counter missed a pulse");
  chk_hs_reset_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_hs_reset[0] |=> o_hs_value[31:0] == 32'h0 && !o_hs_flag[0])
    else $error("high-speed counter reset failed");
  chk_hs_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_shared_input_role_select && !i_hs_reset[HS_N-1] |=> $stable(o_hs_value[(HS_N-1)*32 +: 32]))
    else $error("shared input counted while resetting");
endmodule // ptcu_top

//--- sim/ptcu_scan_model.sv
`timescale 1ns/10ps
// Scan engine stand-in; it stays silent while stopped so no stray step sneaks in.
module ptcu_scan_model #(
  parameter int PERIOD = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_end_of_scan
);
  logic [7:0] cnt_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_run) begin
      cnt_r <= 8'h00;
      o_end_of_scan <= 1'b0;
    end else begin
      o_end_of_scan <= (cnt_r == 8'(PERIOD - 1));
      cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule // ptcu_scan_model

//--- sim/ptcu_top_tb.sv
`timescale 1ns/10ps
module ptcu_top_tb;
  import ptcu_pkg::*;
  localparam int HS_N = 6;
  logic i_sys_clk, i_rst, i_end_of_scan, i_eval_mode, i_tmr_enable, i_tmr_retentive;
  logic i_tmr_routine, i_tmr_routine_active, i_tmr_eval, i_c16_count, i_c16_reset, i_c16_load;
  logic i_c32_count, i_c32_reset, i_count_down_select_bit, i_shared_input_role_select, run;
  logic o_tmr_flag, o_c16_flag, o_c32_flag, dn;
  logic [1:0] i_tmr_base;
  logic [15:0] i_tmr_preset, o_tmr_value;
  logic [14:0] i_c16_load_value, i_c16_preset, o_c16_value;
  logic [31:0] i_c32_preset, i_hs_preset, o_c32_value;
  logic [HS_N-1:0] i_hs_pulse, i_hs_reset, i_hs_down, o_hs_flag;
  logic [HS_N*32-1:0] o_hs_value;
  int bad_count, num_checks, p, k, e;
  ptcu_top #(.TICK_CYC(2), .HS_N(HS_N)) dut (.i_sys_clk, .i_rst, .i_end_of_scan, .i_eval_mode,
    .i_tmr_base, .i_tmr_enable, .i_tmr_retentive, .i_tmr_routine, .i_tmr_routine_active,
    .i_tmr_eval, .i_tmr_preset, .i_c16_count, .i_c16_reset, .i_c16_load, .i_c16_load_value,
    .i_c16_preset, .i_c32_count, .i_c32_reset, .i_count_down_select_bit, .i_c32_preset,
    .i_hs_pulse, .i_hs_reset, .i_hs_down, .i_shared_input_role_select, .i_hs_preset,
    .o_tmr_value, .o_tmr_flag, .o_c16_value, .o_c16_flag, .o_c32_value, .o_c32_flag,
    .o_hs_value, .o_hs_flag);
  ptcu_scan_model #(.PERIOD(8)) scan (.i_sys_clk, .i_rst, .i_run(run),
    .o_end_of_scan(i_end_of_scan));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Runs the scan engine for n strobes, then stops it so checks see a frozen timer.
  task automatic scans(input int n);
    int w;
    w = 0;
    run <= 1'b1;
    repeat (n) begin
      @(posedge i_sys_clk);
      while (i_end_of_scan !== 1'b1 && w < 100) begin
        @(posedge i_sys_clk);
        w++;
      end
    end
    run <= 1'b0;
    if (w >= 100) begin
      bad_count++;
      tally_and_finish();
    end
    cyc(2);
  endtask
  task automatic drive(input int w, input int j, input logic v);
    case (w)
      0: i_c16_count <= v;
      1: i_c32_count <= v;
      default: i_hs_pulse[j] <= v;
    endcase
  endtask
  task automatic edge_on(input int w, input int j);
    drive(w, j, 1'b1);
    cyc(1);
    drive(w, j, 1'b0);
    cyc(1);
  endtask
  function automatic logic [31:0] exp_c16(input int n, input int pre);
    return (n >= pre) ? (32'h00008000 | 32'(pre)) : 32'(n);
  endfunction
  function automatic logic [31:0] tmr();
    return {15'h0000, o_tmr_flag, o_tmr_value};
  endfunction
  initial begin
    i_rst = 1'b1;
    run = 1'b0;
    {i_eval_mode, i_tmr_enable, i_tmr_retentive, i_tmr_routine, i_tmr_eval} = '0;
    {i_c16_count, i_c16_reset, i_c16_load, i_c32_count, i_c32_reset} = '0;
    {i_count_down_select_bit, i_shared_input_role_select} = '0;
    i_tmr_routine_active = 1'b1;
    i_tmr_base = PTCU_TB_1MS;
    i_tmr_preset = 16'h0003;
    {i_c16_load_value, i_c16_preset, i_c32_preset, i_hs_preset} = '0;
    {i_hs_pulse, i_hs_reset, i_hs_down} = '0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(44));
    cyc(4);
    i_rst <= 1'b0;
    cyc(1);
    i_tmr_enable <= 1'b1;
    scans(2);
    chk(tmr(), 32'h00000002);
    scans(1);
    chk(tmr(), 32'h00010003);
    i_tmr_enable <= 1'b0;
    cyc(2);
    chk(tmr(), 32'h00000000);
    i_tmr_retentive <= 1'b1;
    i_tmr_enable <= 1'b1;
    scans(2);
    i_tmr_enable <= 1'b0;
    scans(2);
    chk(tmr(), 32'h00000002);
    i_tmr_enable <= 1'b1;
    scans(1);
    chk(tmr(), 32'h00010003);
    i_rst <= 1'b1;
    i_tmr_enable <= 1'b0;
    i_tmr_retentive <= 1'b0;
    i_eval_mode <= 1'b1;
    cyc(1);
    i_rst <= 1'b0;
    i_tmr_enable <= 1'b1;
    cyc(3);
    repeat (2) begin
      i_tmr_eval <= 1'b1;
      cyc(1);
      i_tmr_eval <= 1'b0;
      cyc(3);
    end
    scans(1);
    chk(tmr(), 32'h00000002);
    i_eval_mode <= 1'b0;
    i_tmr_enable <= 1'b0;
    cyc(2);
    i_tmr_routine <= 1'b1;
    i_tmr_enable <= 1'b1;
    scans(2);
    chk(tmr(), 32'h00000002);
    i_tmr_routine_active <= 1'b0;
    scans(2);
    chk(tmr(), 32'h00000002);
    i_tmr_routine_active <= 1'b1;
    i_rst <= 1'b1;
    i_tmr_routine <= 1'b0;
    i_tmr_enable <= 1'b0;
    i_tmr_base <= PTCU_TB_100MS;
    i_tmr_preset <= 16'h00ff;
    i_eval_mode <= 1'b1;
    i_tmr_eval <= 1'b1;
    cyc(1);
    i_rst <= 1'b0;
    i_tmr_enable <= 1'b1;
    cyc(300);
    chk(tmr(), 32'h00000001);
    {i_eval_mode, i_tmr_eval} <= 2'h0;
    i_tmr_base <= PTCU_TB_1MS;
    i_tmr_enable <= 1'b0;
    p = 3 + int'($urandom % 5);
    i_c16_preset <= 15'(p);
    cyc(1);
    for (k = 1; k <= p + 1; k++) begin
      edge_on(0, 0);
      chk({16'h0000, o_c16_flag, o_c16_value}, exp_c16(k, p));
    end
    i_c16_reset <= 1'b1;
    cyc(1);
    i_c16_reset <= 1'b0;
    cyc(2);
    chk({16'h0000, o_c16_flag, o_c16_value}, 32'h00000000);
    i_c16_load_value <= 15'(p + 5);
    i_c16_load <= 1'b1;
    cyc(1);
    i_c16_load <= 1'b0;
    cyc(2);
    edge_on(0, 0);
    chk({16'h0000, o_c16_flag, o_c16_value}, exp_c16(p, p));
    i_c32_preset <= 32'hffffffff;
    e = 0;
    for (k = 0; k < 6; k++) begin
      dn = (k == 0) ? 1'b1 : 1'($urandom % 2);
      i_count_down_select_bit <= dn;
      cyc(1);
      edge_on(1, 0);
      chk(o_c32_value, 32'(e));
      e = dn ? e - 1 : e + 1;
      scans(1);
      chk(o_c32_value, 32'(e));
      chk({31'h0, o_c32_flag}, {31'h0, e >= -1});
    end
    i_c32_reset <= 1'b1;
    scans(1);
    i_c32_reset <= 1'b0;
    chk(o_c32_value, 32'h00000000);
    for (k = 0; k < HS_N; k++) begin
      p = 1 + int'($urandom % 4);
      i_hs_preset <= 32'(p);
      cyc(1);
      repeat (p) edge_on(2, k);
      chk(o_hs_value[k*32+:32], 32'(p));
      chk({31'h0, o_hs_flag[k]}, 32'h00000001);
      edge_on(2, k);
      chk(o_hs_value[k*32+:32], 32'(p + 1));
      i_hs_reset[k] <= 1'b1;
      cyc(1);
      i_hs_reset[k] <= 1'b0;
      cyc(2);
      chk({o_hs_value[k*32+:31], o_hs_flag[k]}, 32'h00000000);
    end
    i_shared_input_role_select <= 1'b1;
    for (k = 0; k < 5; k++) edge_on(2, k);
    i_hs_pulse[5] <= 1'b1;
    cyc(3);
    i_hs_pulse[5] <= 1'b0;
    cyc(2);
    for (k = 0; k < HS_N; k++) chk(o_hs_value[k*32+:32], 32'h00000000);
    i_shared_input_role_select <= 1'b0;
    cyc(1);
    edge_on(2, 5);
    chk(o_hs_value[160+:32], 32'h00000001);
    i_hs_down[5] <= 1'b1;
    cyc(1);
    edge_on(2, 5);
    chk(o_hs_value[160+:32], 32'h00000000);
    tally_and_finish();
  end
endmodule // ptcu_top_tb
